// [design/ldss_pkg.sv]
// Overview of operation
// - data input shifts into a 16-bit register on each serial clock rise
// - latch strobe rise copies the data byte into the addressed register
// - cascade output repeats shifted data 15.5 cycles later on falling edges
// - frame: four ignored bits, 4-bit address, 8-bit data in low bits
// - frames go most significant bit first, bit 15 enters first
// - fourteen registers selected by the 4-bit address field
// - eight 8-bit digit registers; one write leaves the others intact
// - control registers: decode, intensity, scan limit, shutdown, test, reset/clock
// - shutdown register at address 0Ch enters and leaves blanked mode
// - in shutdown segment lines go low and digit lines go high
// - shutdown keeps the digit registers; values return on wake
// - display output resumes about 250 us after return to normal
// - frames are accepted and registers written during shutdown
// - display test drives the display even in shutdown
// - a segment line that is off is driven to ground
// - address codes: 0 no-op, 1-8 digits, 9 to F controls, D unused
// - shutdown bit 0: 0 shutdown, 1 normal; other bits ignored
// - power-up: all registers cleared, shutdown, one digit, no decode, min intensity
package ldss_pkg;
	localparam int          FRAME_W      = 16;
	localparam int          ADDR_LSB     = 8;
	localparam int          ADDR_W       = 4;
	localparam int          DATA_W       = 8;
	localparam int          DIGITS       = 8;
	localparam logic [3:0]  ADDR_NOOP    = 4'h0;
	localparam logic [3:0]  ADDR_DIG0    = 4'h1;
	localparam logic [3:0]  ADDR_DIG7    = 4'h8;
	localparam logic [3:0]  ADDR_DECODE  = 4'h9;
	localparam logic [3:0]  ADDR_INTENS  = 4'hA;
	localparam logic [3:0]  ADDR_SCAN    = 4'hB;
	localparam logic [3:0]  ADDR_SHUT    = 4'hC;
	localparam logic [3:0]  ADDR_UNUSED  = 4'hD;
	localparam logic [3:0]  ADDR_RSTCLK  = 4'hE;
	localparam logic [3:0]  ADDR_TEST    = 4'hF;
	localparam int          SHUT_BIT     = 0;
	localparam int          TEST_BIT     = 0;
	localparam logic [7:0]  REG_RESET    = 8'h00;
	localparam int          WAKE_NS      = 250000;
	localparam int          CLK_NS       = 40;
	localparam int          WAKE_CYCLES  = WAKE_NS / CLK_NS;
	localparam logic [1:0]  SYNC_AGREE   = 2'b11;
endpackage

// [design/ldss_serial.sv]
`timescale 1ns/10ps
// link-clock side: shift register, cascade output, latch capture
module ldss_serial (
	input  wire logic        i_sclk,
	input  wire logic        i_din,
	input  wire logic        i_load,
	output logic             o_dout,
	output logic [15:0]      o_frame,
	output logic             o_tog
);
	typedef struct packed {
		logic [15:0] sh;
		logic [15:0] frame;
		logic        tog;
		logic        load_prev;
	} ldss_ser_t;

	// power-up state: the link side has no reset pin
	ldss_ser_t s_q = '0;
	ldss_ser_t s_d;
	logic      dout_q = 1'b0;

	always_comb begin
		s_d           = s_q;
		s_d.sh        = {s_q.sh[14:0], i_din};
		s_d.load_prev = i_load;
		if (i_load && !s_q.load_prev) begin
			s_d.frame = s_q.sh;
			s_d.tog   = ~s_q.tog;
		end
	end

	always_ff @(posedge i_sclk) begin
		s_q <= s_d;
	end

	// msb of the shifter leaves on the falling edge
	always_ff @(negedge i_sclk) begin
		dout_q <= s_q.sh[15];
	end

	assign o_dout  = dout_q;
	assign o_frame = s_q.frame;
	assign o_tog   = s_q.tog;
endmodule

// [design/ldss_top.sv]
`timescale 1ns/10ps
module ldss_top #(
	parameter int WAKE_CYCLES = ldss_pkg::WAKE_CYCLES
) (
	input  wire logic        i_clk,
	input  wire logic        i_srst,
	input  wire logic        i_sclk,
	input  wire logic        i_din,
	input  wire logic        i_load,
	output logic             o_dout,
	output logic [7:0]       o_segment_source_lines,
	output logic [7:0]       o_digit_sink_lines,
	output logic             o_shutdown,
	output logic [7:0]       o_decode_mode,
	output logic [3:0]       o_intensity,
	output logic [2:0]       o_scan_limit,
	output logic [7:0]       o_rst_extclk,
	output logic             o_display_test
);
	////////////////////////////////////////////////////////////////////////////////
	localparam int WAIT_W = $clog2(WAKE_CYCLES + 1);

	typedef enum logic [1:0] {ST_SHUT, ST_WAKE, ST_RUN} ldss_mode_t;

	typedef struct packed {
		logic [63:0]  digits;
		logic [7:0]   decode;
		logic [7:0]   intens;
		logic [7:0]   scan;
		logic [7:0]   shut;
		logic [7:0]   rstclk;
		logic [7:0]   test;
		logic [2:0]   tog_sync;
		logic         tog_seen;
		logic [15:0]  frame;
		logic         commit;
		logic [2:0]   mux;
		logic [7:0]   seg;
		logic [7:0]   dig;
		logic         shut_out;
		logic [WAIT_W-1:0] wait_cnt;
		ldss_mode_t   mode;
	} ldss_state_t;

	ldss_state_t q;
	ldss_state_t d;
	logic [15:0] frame_w;
	logic        tog_w;
	logic [3:0]  addr;
	logic [7:0]  wdata;
	logic        settled;
	logic        fresh;
	logic        live;
	logic [7:0]  cur_byte;

	// active-low select of the scanned digit
	function automatic logic [7:0] digit_select(input logic [2:0] idx);
		digit_select = ~(8'h01 << idx);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	ldss_serial u_serial (
		.i_sclk  (i_sclk),
		.i_din   (i_din),
		.i_load  (i_load),
		.o_dout  (o_dout),
		.o_frame (frame_w),
		.o_tog   (tog_w)
	);

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		d            = q;
		d.tog_sync   = {q.tog_sync[1:0], tog_w};
		settled      = (q.tog_sync[2] == q.tog_sync[1]);
		fresh        = settled && (q.tog_sync[2] != q.tog_seen);
		addr         = q.frame[ldss_pkg::ADDR_LSB +: ldss_pkg::ADDR_W];
		wdata        = q.frame[ldss_pkg::DATA_W-1:0];
		live         = (q.mode == ST_RUN) || q.test[ldss_pkg::TEST_BIT];
		cur_byte     = q.digits[q.mux*ldss_pkg::DATA_W +: ldss_pkg::DATA_W];
		// the frame word settled long before its toggle agreed, so it is copied whole
		d.commit     = fresh;
		if (fresh) begin
			d.tog_seen = q.tog_sync[2];
			d.frame    = frame_w;
		end
		// the copied frame is committed one cycle later
		if (q.commit) begin
			case (addr)
				ldss_pkg::ADDR_NOOP, ldss_pkg::ADDR_UNUSED: begin
				end
				ldss_pkg::ADDR_DECODE: d.decode = wdata;
				ldss_pkg::ADDR_INTENS: d.intens = wdata;
				ldss_pkg::ADDR_SCAN:   d.scan   = wdata;
				ldss_pkg::ADDR_SHUT: begin
					d.shut     = wdata;
					d.shut_out = ~wdata[ldss_pkg::SHUT_BIT];
				end
				ldss_pkg::ADDR_RSTCLK: d.rstclk = wdata;
				ldss_pkg::ADDR_TEST:   d.test   = wdata;
				default: begin
					if (addr >= ldss_pkg::ADDR_DIG0 && addr <= ldss_pkg::ADDR_DIG7) begin
						d.digits[3'(addr - ldss_pkg::ADDR_DIG0)*ldss_pkg::DATA_W +: ldss_pkg::DATA_W] = wdata;
					end
				end
			endcase
		end
		// shutdown sequencing with wake delay
		case (q.mode)
			ST_SHUT: begin
				d.wait_cnt = '0;
				if (q.shut[ldss_pkg::SHUT_BIT]) begin
					d.mode = ST_WAKE;
				end
			end
			ST_WAKE: begin
				d.wait_cnt = q.wait_cnt + WAIT_W'(1);
				if (!q.shut[ldss_pkg::SHUT_BIT]) begin
					d.mode = ST_SHUT;
				end else if (q.wait_cnt >= WAIT_W'(WAKE_CYCLES - 1)) begin
					d.mode = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!q.shut[ldss_pkg::SHUT_BIT]) begin
					d.mode = ST_SHUT;
				end
			end
			default: d.mode = ST_SHUT;
		endcase
		// simple digit scan across the enabled digits
		if (q.mux >= q.scan[2:0]) begin
			d.mux = 3'h0;
		end else begin
			d.mux = q.mux + 3'h1;
		end
		if (!live) begin
			d.seg = 8'h00;
			d.dig = 8'hFF;
		end else if (q.test[ldss_pkg::TEST_BIT]) begin
			d.seg = 8'hFF;
			d.dig = digit_select(q.mux);
		end else begin
			d.seg = cur_byte;
			d.dig = digit_select(q.mux);
		end
		if (i_srst) begin
			d        = '0;
			d.mode   = ST_SHUT;
			d.dig    = 8'hFF;
			d.shut_out = 1'b1;
			d.tog_sync = {q.tog_sync[1:0], tog_w};
			d.tog_seen = q.tog_sync[2];
		end
	end

	always_ff @(posedge i_clk) begin
		q <= d;
	end

	////////////////////////////////////////////////////////////////////////////////
	assign o_segment_source_lines = q.seg;
	assign o_digit_sink_lines     = q.dig;
	assign o_shutdown             = q.shut_out;
	assign o_decode_mode          = q.decode;
	assign o_intensity            = q.intens[3:0];
	assign o_scan_limit           = q.scan[2:0];
	assign o_rst_extclk           = q.rstclk;
	assign o_display_test         = q.test[ldss_pkg::TEST_BIT];
endmodule

// [tb/ldss_host.sv]
`timescale 1ns/10ps
module ldss_host (
	output logic o_sclk,
	output logic o_din,
	output logic o_load
);
	initial begin
		o_sclk = 1'b0;
		o_din  = 1'b0;
		o_load = 1'b0;
	end
	task automatic pulse();
		#7.5 o_sclk = 1'b1;
		#7.5 o_sclk = 1'b0;
	endtask
	// serial clock only runs inside a send: 16 bit pulses, then 3 more with latch high
	task automatic send(input logic [15:0] f);
		#3;
		for (int i = 15; i >= 0; i--) begin
			o_din = f[i];
			pulse();
		end
		o_load = 1'b1;
		o_din  = ~o_din;
		repeat (3) pulse();
		o_load = 1'b0;
	endtask
endmodule

// [tb/ldss_props.sv]
`timescale 1ns/10ps
module ldss_props #(
	parameter int WAKE_CYCLES = 8
) (
	input wire logic       i_clk,
	input wire logic       i_srst,
	input wire logic       i_sclk,
	input wire logic       i_din,
	input wire logic       i_load,
	input wire logic       o_dout,
	input wire logic [7:0] o_segment_source_lines,
	input wire logic [7:0] o_digit_sink_lines,
	input wire logic       o_shutdown,
	input wire logic       o_display_test
);
	int   n_sk = 0;
	logic dq;
	always_ff @(posedge i_sclk) begin
		n_sk <= n_sk + 1;
		dq   <= o_dout;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	sequence blank_s;
		o_shutdown && !o_display_test;
	endsequence
	a_shut_seg: assert property (blank_s[*3] |-> o_segment_source_lines == 8'h00)
		else $error("segments lit in shutdown");
	a_shut_dig: assert property (blank_s[*3] |-> o_digit_sink_lines == 8'hFF)
		else $error("digit driven in shutdown");
	a_test_lit: assert property (o_display_test[*3] |-> o_segment_source_lines == 8'hFF)
		else $error("display test not lit");
	a_wake_wait: assert property ($fell(o_shutdown) && !o_display_test |=> (o_digit_sink_lines == 8'hFF)[*4])
		else $error("display resumed too early");
	a_shut_hold: assert property (!i_load[*8] |-> $stable(o_shutdown))
		else $error("shutdown changed without latch");
	a_test_hold: assert property (!i_load[*8] |-> $stable(o_display_test))
		else $error("test changed without latch");
	a_dout_lag: assert property (@(posedge i_sclk) disable iff (n_sk < 18) o_dout == $past(i_din, 16))
		else $error("cascade output lag wrong");
	a_dout_fall: assert property (@(negedge i_sclk) disable iff (n_sk < 18) o_dout == dq)
		else $error("cascade output moved on rising edge");
endmodule
bind ldss_top ldss_props #(.WAKE_CYCLES(WAKE_CYCLES)) u_props (.i_clk(i_clk), .i_srst(i_srst),
	.i_sclk(i_sclk), .i_din(i_din), .i_load(i_load), .o_dout(o_dout), .o_shutdown(o_shutdown),
	.o_segment_source_lines(o_segment_source_lines), .o_digit_sink_lines(o_digit_sink_lines),
	.o_display_test(o_display_test));

// [tb/ldss_top_test.sv]
`timescale 1ns/10ps
module ldss_top_test;
	logic       i_clk, i_srst, sclk, din, load, dout, shut, tst;
	logic [7:0] seg, dig, dec, rc;
	logic [3:0] inten;
	logic [2:0] scan;
	logic [7:0] mem [8];
	int         n_errors = 0;
	int         n_compared = 0;
	ldss_host u_host (.o_sclk(sclk), .o_din(din), .o_load(load));
	ldss_top #(.WAKE_CYCLES(8)) u_dut (.i_clk(i_clk), .i_srst(i_srst), .i_sclk(sclk), .i_din(din),
		.i_load(load), .o_dout(dout), .o_segment_source_lines(seg), .o_digit_sink_lines(dig),
		.o_shutdown(shut), .o_decode_mode(dec), .o_intensity(inten), .o_scan_limit(scan),
		.o_rst_extclk(rc), .o_display_test(tst));
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// top nibble set on purpose: it must be ignored
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		u_host.send({4'hF, a, d});
		repeat (8) @(posedge i_clk);
		#1;
	endtask
	task automatic show();
		logic seen;
		seen = 1'b0;
		repeat (40) begin
			@(posedge i_clk);
			#1;
			for (int k = 0; k < 8; k++) if (dig[k] === 1'b0) begin
				seen = 1'b1;
				chk({8'h00, seg}, {8'h00, mem[k]});
			end
		end
		chk({15'h0, seen}, 16'h0001);
	endtask
	task automatic reset_and_check(input int n);
		i_srst = 1'b1;
		repeat (n) @(posedge i_clk);
		#1 i_srst = 1'b0;
		repeat (4) @(posedge i_clk);
		#1;
		chk({shut, tst, scan, 3'h0, seg}, 16'h8000);
		chk({dec, dig}, 16'h00FF);
	endtask
	task automatic tally_and_finish();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		reset_and_check(12);
		wr(4'h9, 8'hA5);
		wr(4'hA, 8'h0C);
		wr(4'hB, 8'h07);
		wr(4'hE, 8'h3C);
		wr(4'h0, 8'h00);
		wr(4'hD, 8'h00);
		chk({dec, rc}, 16'hA53C);
		chk({4'h0, inten, 5'h0, scan}, 16'h0C07);
		for (int k = 0; k < 8; k++) begin
			mem[k] = 8'h81 + 8'(k * 3);
			wr(4'(k + 1), mem[k]);
		end
		chk({seg, dig}, 16'h00FF);
		wr(4'hF, 8'h01);
		chk({7'h0, tst, seg}, 16'h01FF);
		wr(4'hF, 8'h00);
		u_host.send({4'h0, 4'hC, 8'hFF});
		repeat (6) @(posedge i_clk);
		#1;
		chk({7'h0, shut, dig}, 16'h00FF);
		show();
		mem[3] = 8'h5A;
		wr(4'h4, 8'h5A);
		wr(4'hC, 8'hFE);
		chk({7'h0, shut, seg}, 16'h0100);
		wr(4'hC, 8'h01);
		show();
		reset_and_check(3);
		wr(4'hA, 8'h05);
		chk({12'h0, inten}, 16'h0005);
		tally_and_finish();
	end
endmodule
